// ==== core/sppp_params.svh ====
// What this block does
// - Enabled peripheral owns pin, port control off
// - Peripheral functions disabled out of reset, except debug select on pin four
// - Reset: all pins but output-only pin four input, pullups off
// - Output-only pin starts as debug mode select
// - Four bidirectional, one output-only, one input-only
// - Data register for pins, direction register separate
// - Pullup off when pin driven as output
// - Pullup off under analog control
// - Pullup register bits 5:0, one enables
// - Pullup bit four has no effect
// - Slew bit limits output transition rate
// - Slew bit ignored on input pins
// - Slew register bits 5:0, reset all ones
// - Slew bit five has no effect
`ifndef SPPP_PARAMS_SVH
`define SPPP_PARAMS_SVH

`define SPPP_NPINS        6
`define SPPP_OUT_ONLY_IDX 4
`define SPPP_IN_ONLY_IDX  5
`define SPPP_OFF_DATA     12'h000
`define SPPP_OFF_DIR      12'h004
`define SPPP_OFF_PULLUP   12'h008
`define SPPP_OFF_SLEW     12'h00C
`define SPPP_OFF_PERIPH   12'h010
`define SPPP_OFF_PIN_IN   12'h014
`define SPPP_OFF_OWNER    12'h018
`define SPPP_RST_DATA     6'h00
`define SPPP_RST_DIR      6'h00
`define SPPP_RST_PULLUP   6'h00
`define SPPP_RST_SLEW     6'h3F
`define SPPP_RST_PERIPH   6'h00
`define SPPP_RST_DBG_SEL  1'h1

`endif

// ==== core/sppp_pkg.sv ====
package sppp_pkg;
	typedef enum logic [1:0] {
		SPPP_IDLE  = 2'h0,
		SPPP_WRITE = 2'h1,
		SPPP_READ  = 2'h2
	} sppp_bus_state_t;
endpackage

// ==== core/sppp_pin_cell.sv ====
`timescale 1ns/1ps
`include "sppp_params.svh"
module sppp_pin_cell
	import sppp_pkg::*;
#(
	parameter bit CAN_OUT = 1'b1,
	parameter bit CAN_IN  = 1'b1
) (
	// Port settings
	input  wire logic port_dat_i,
	input  wire logic port_dir_i,
	input  wire logic pullup_bit_i,
	input  wire logic slew_bit_i,
	// Peripheral claim
	input  wire logic periph_en_i,
	input  wire logic periph_oe_i,
	input  wire logic periph_out_i,
	input  wire logic analog_en_i,
	// Pad controls
	output logic      pad_out_o,
	output logic      pad_oe_o,
	output logic      pad_pullup_o,
	output logic      pad_slew_o
);
	logic oe;
	always_comb begin
		if (analog_en_i) begin
			oe = 1'b0;
		end else if (periph_en_i) begin
			oe = periph_oe_i;
		end else begin
			oe = port_dir_i;
		end
		if (!CAN_OUT) begin
			oe = 1'b0;
		end
		pad_oe_o = oe;
		pad_out_o = periph_en_i ? periph_out_i : port_dat_i;
		pad_pullup_o = CAN_IN && pullup_bit_i && !oe && !analog_en_i;
		pad_slew_o = CAN_OUT && slew_bit_i && oe;
	end
endmodule

// ==== core/sppp_ahb_slave.sv ====
`timescale 1ns/1ps
module sppp_ahb_slave
	import sppp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// AHB-Lite
	input  wire logic        hsel_i,
	input  wire logic [11:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic        hready_i,
	// Register side
	output logic             wr_en_o,
	output logic             rd_en_o,
	output logic [11:0]      addr_o
);
	sppp_bus_state_t state_q;
	logic [11:0]     addr_q;
	logic            take;
	assign take = hsel_i && htrans_i[1] && hready_i;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= SPPP_IDLE;
		end else if (take) begin
			state_q <= hwrite_i ? SPPP_WRITE : SPPP_READ;
		end else if (hready_i) begin
			state_q <= SPPP_IDLE;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			addr_q <= 12'h000;
		end else if (take) begin
			addr_q <= {haddr_i[11:2], 2'h0};
		end
	end
	assign wr_en_o = (state_q == SPPP_WRITE);
	assign rd_en_o = take && !hwrite_i;
	// The write address is always the stored one, so a read taken during a write's data phase
	// cannot redirect that write to the read's register.
	assign addr_o  = addr_q;
endmodule

// ==== core/sppp_port.sv ====
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sppp_params.svh"
module sppp_port
	import sppp_pkg::*;
#(
	parameter int NPINS = `SPPP_NPINS
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// AHB-Lite slave
	input  wire logic             hsel_i,
	input  wire logic [31:0]      haddr_i,
	input  wire logic [1:0]       htrans_i,
	input  wire logic             hwrite_i,
	input  wire logic [2:0]       hsize_i,
	input  wire logic [31:0]      hwdata_i,
	input  wire logic             hready_i,
	output logic      [31:0]      hrdata_o,
	output logic                  hreadyout_o,
	output logic                  hresp_o,
	// Peripheral claim per pin
	input  wire logic [NPINS-1:0] periph_oe_i,
	input  wire logic [NPINS-1:0] periph_out_i,
	input  wire logic [NPINS-1:0] analog_en_i,
	output logic      [NPINS-1:0] periph_en_o,
	output logic                  debug_mode_select_o,
	// Pads
	input  wire logic [NPINS-1:0] pad_in_i,
	output logic      [NPINS-1:0] pad_out_o,
	output logic      [NPINS-1:0] pad_oe_o,
	output logic      [NPINS-1:0] pad_pullup_o,
	output logic      [NPINS-1:0] pad_slew_o
);
	logic [NPINS-1:0] data_q;
	logic [NPINS-1:0] dir_q;
	logic [NPINS-1:0] pullup_q;
	logic [NPINS-1:0] slew_q;
	logic [NPINS-1:0] periph_q;
	logic             dbg_sel_q;
	logic [NPINS-1:0] pin_q;
	logic [NPINS-1:0] eff_periph;
	logic [NPINS-1:0] c_out;
	logic [NPINS-1:0] c_oe;
	logic [NPINS-1:0] c_pu;
	logic [NPINS-1:0] c_sl;
	logic             wr_en;
	logic             rd_en;
	logic [11:0]      addr;
	logic [31:0]      rd_d;
	logic [11:0]      rd_addr;
	logic             wr_data;
	logic             wr_dir;
	logic             wr_pullup;
	logic             wr_slew;
	logic             wr_periph;

	sppp_ahb_slave u_bus (
		.clk_i    (clk_i),
		.srst_i   (srst_i),
		.hsel_i   (hsel_i),
		.haddr_i  (haddr_i[11:0]),
		.htrans_i (htrans_i),
		.hwrite_i (hwrite_i),
		.hready_i (hready_i),
		.wr_en_o  (wr_en),
		.rd_en_o  (rd_en),
		.addr_o   (addr)
	);

	// Reads decode the live address phase, writes the stored one.
	assign rd_addr = {haddr_i[11:2], 2'h0};

	always_comb begin
		wr_data   = 1'b0;
		wr_dir    = 1'b0;
		wr_pullup = 1'b0;
		wr_slew   = 1'b0;
		wr_periph = 1'b0;
		if (wr_en && addr == `SPPP_OFF_DATA) begin
			wr_data = 1'b1;
		end else if (wr_en && addr == `SPPP_OFF_DIR) begin
			wr_dir = 1'b1;
		end else if (wr_en && addr == `SPPP_OFF_PULLUP) begin
			wr_pullup = 1'b1;
		end else if (wr_en && addr == `SPPP_OFF_SLEW) begin
			wr_slew = 1'b1;
		end else if (wr_en && addr == `SPPP_OFF_PERIPH) begin
			wr_periph = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_q <= `SPPP_RST_DATA;
		end else if (wr_data) begin
			data_q <= hwdata_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dir_q <= `SPPP_RST_DIR;
		end else if (wr_dir) begin
			dir_q <= hwdata_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pullup_q <= `SPPP_RST_PULLUP;
		end else if (wr_pullup) begin
			pullup_q <= hwdata_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			slew_q <= `SPPP_RST_SLEW;
		end else if (wr_slew) begin
			slew_q <= hwdata_i[NPINS-1:0];
		end
	end

	// Bit NPINS of the peripheral enable register holds the debug select of the output-only pin.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			periph_q  <= `SPPP_RST_PERIPH;
			dbg_sel_q <= `SPPP_RST_DBG_SEL;
		end else if (wr_periph) begin
			periph_q  <= hwdata_i[NPINS-1:0];
			dbg_sel_q <= hwdata_i[NPINS];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_q <= '0;
		end else begin
			pin_q <= pad_in_i;
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (rd_addr == `SPPP_OFF_DATA) begin
			// Pins with their direction bit set read back the latch, the others read the pad.
			rd_d[NPINS-1:0] = (data_q & dir_q) | (pin_q & ~dir_q);
		end else if (rd_addr == `SPPP_OFF_DIR) begin
			rd_d[NPINS-1:0] = dir_q;
		end else if (rd_addr == `SPPP_OFF_PULLUP) begin
			rd_d[NPINS-1:0] = pullup_q;
		end else if (rd_addr == `SPPP_OFF_SLEW) begin
			rd_d[NPINS-1:0] = slew_q;
		end else if (rd_addr == `SPPP_OFF_PERIPH) begin
			rd_d[NPINS:0] = {dbg_sel_q, periph_q};
		end else if (rd_addr == `SPPP_OFF_PIN_IN) begin
			rd_d[NPINS-1:0] = pin_q;
		end else if (rd_addr == `SPPP_OFF_OWNER) begin
			rd_d[NPINS-1:0] = eff_periph | analog_en_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (rd_en) begin
			hrdata_o <= rd_d;
		end
	end

	// Zero wait states and an OKAY response, still taken from flops like every other output.
	always_ff @(posedge clk_i) begin
		hreadyout_o <= 1'b1;
		hresp_o     <= 1'b0;
	end

	always_comb begin
		eff_periph = periph_q;
		eff_periph[`SPPP_OUT_ONLY_IDX] = periph_q[`SPPP_OUT_ONLY_IDX] | dbg_sel_q;
	end

	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			sppp_pin_cell #(
				.CAN_OUT (g != `SPPP_IN_ONLY_IDX),
				.CAN_IN  (g != `SPPP_OUT_ONLY_IDX)
			) u_cell (
				.port_dat_i   (data_q[g]),
				.port_dir_i   (dir_q[g] | (g == `SPPP_OUT_ONLY_IDX)),
				.pullup_bit_i (pullup_q[g]),
				.slew_bit_i   (slew_q[g]),
				.periph_en_i  (eff_periph[g]),
				.periph_oe_i  (periph_oe_i[g]),
				.periph_out_i (periph_out_i[g]),
				.analog_en_i  (analog_en_i[g]),
				.pad_out_o    (c_out[g]),
				.pad_oe_o     (c_oe[g]),
				.pad_pullup_o (c_pu[g]),
				.pad_slew_o   (c_sl[g])
			);
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pad_out_o           <= '0;
			pad_oe_o            <= '0;
			pad_pullup_o        <= '0;
			pad_slew_o          <= '0;
			periph_en_o         <= '0;
			debug_mode_select_o <= 1'b0;
		end else begin
			pad_out_o           <= c_out;
			pad_oe_o            <= c_oe;
			pad_pullup_o        <= c_pu;
			pad_slew_o          <= c_sl;
			periph_en_o         <= eff_periph;
			debug_mode_select_o <= dbg_sel_q;
		end
	end
endmodule

// ==== tb/sppp_port_monitor.sv ====
`timescale 1ns/1ps
module sppp_port_monitor #(
	parameter int NPINS = 6
) (
	input wire logic             clk_i,
	input wire logic             srst_i,
	input wire logic             hsel_i,
	input wire logic [31:0]      haddr_i,
	input wire logic [1:0]       htrans_i,
	input wire logic             hwrite_i,
	input wire logic             hready_i,
	input wire logic [31:0]      hrdata_o,
	input wire logic [NPINS-1:0] periph_oe_i,
	input wire logic [NPINS-1:0] analog_en_i,
	input wire logic [NPINS-1:0] periph_en_o,
	input wire logic             debug_mode_select_o,
	input wire logic [NPINS-1:0] pad_oe_o,
	input wire logic [NPINS-1:0] pad_pullup_o,
	input wire logic [NPINS-1:0] pad_slew_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence rd_ctl;
		hsel_i && htrans_i[1] && !hwrite_i && hready_i && haddr_i[11:3] == 9'h001;
	endsequence
	chk_pull_drive: assert property ((pad_pullup_o & pad_oe_o) == 6'h00)
		else $error("pullup on driven pin");
	chk_pull_analog: assert property ((pad_pullup_o & $past(analog_en_i)) == 6'h00)
		else $error("pullup on analog pin");
	chk_pull_four: assert property (!pad_pullup_o[4])
		else $error("pullup on output-only pin");
	chk_slew_input: assert property ((pad_slew_o & ~pad_oe_o) == 6'h00)
		else $error("slew on input pin");
	chk_in_only: assert property (!pad_oe_o[5])
		else $error("input-only pin driven");
	chk_reset_pins: assert property ($fell(srst_i) |=> pad_pullup_o == 6'h00 && pad_oe_o[3:0] == 4'h0 && periph_en_o[3:0] == 4'h0)
		else $error("pins not inputs after reset");
	chk_debug_start: assert property ($fell(srst_i) |=> debug_mode_select_o && periph_en_o[4])
		else $error("debug select not set after reset");
	chk_periph_oe: assert property (((pad_oe_o ^ ($past(periph_oe_i) & ~$past(analog_en_i))) & periph_en_o & 6'h1F) == 6'h00)
		else $error("owned pin not under peripheral");
	chk_ctl_upper: assert property (rd_ctl |=> hrdata_o[31:6] == 26'h0)
		else $error("upper control bits not zero");
endmodule
bind sppp_port sppp_port_monitor #(.NPINS(NPINS)) u_mon (.clk_i(clk_i), .srst_i(srst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .periph_oe_i(periph_oe_i),
	.analog_en_i(analog_en_i), .periph_en_o(periph_en_o),
	.debug_mode_select_o(debug_mode_select_o), .pad_oe_o(pad_oe_o),
	.pad_pullup_o(pad_pullup_o), .pad_slew_o(pad_slew_o));

// ==== tb/sppp_pin_model.sv ====
`timescale 1ns/1ps
module sppp_pin_model (
	input  wire logic       clk_i,
	input  wire logic [5:0] pad_out_i,
	input  wire logic [5:0] pad_oe_i,
	input  wire logic [5:0] pad_pullup_i,
	output logic      [5:0] pad_in_o
);
	logic [5:0] tog_q = 6'h00;
	// A floating pin shows a changing level so that no value is read by luck.
	always @(posedge clk_i) tog_q <= ~tog_q;
	assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (pad_pullup_i | tog_q));
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic        clk_i, srst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, dbg;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
	logic [1:0]  htrans_i;
	logic [5:0]  p_oe, p_out, an, p_en, p_in, q_out, q_oe, q_pu, q_sl;
	int          n_errors = 0;
	int          total_checks = 0;
	sppp_port dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .periph_oe_i(p_oe), .periph_out_i(p_out), .analog_en_i(an),
		.periph_en_o(p_en), .debug_mode_select_o(dbg), .pad_in_i(p_in), .pad_out_o(q_out),
		.pad_oe_o(q_oe), .pad_pullup_o(q_pu), .pad_slew_o(q_sl));
	sppp_pin_model u_pins (.clk_i(clk_i), .pad_out_i(q_out), .pad_oe_i(q_oe),
		.pad_pullup_i(q_pu), .pad_in_o(p_in));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i  <= {20'h0, a};
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i   <= 1'b0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
		chk("hresp", 32'h0, {31'h0, hresp_o});
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, r);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		finish_test;
	end
	initial begin
		{srst_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = {3'h5, 66'h0};
		{p_oe, p_out, an} = {6'h10, 12'h0};
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		settle;
		chk("dbg", 32'h1, {31'h0, dbg});
		chk("pen", 32'h10, {26'h0, p_en});
		chk("oe", 32'h10, {26'h0, q_oe});
		chk("pu", 32'h0, {26'h0, q_pu});
		rdc("dir", 12'h004, 32'h0);
		rdc("pu", 12'h008, 32'h0);
		rdc("slew", 12'h00C, 32'h3F);
		rdc("periph", 12'h010, 32'h40);
		rdc("unmapped", 12'h100, 32'h0);
		ahb(1'b1, 12'h008, 32'hFF);
		rdc("pu", 12'h008, 32'h3F);
		settle;
		chk("pu", 32'h2F, {26'h0, q_pu});
		ahb(1'b1, 12'h004, 32'h0F);
		ahb(1'b1, 12'h000, 32'h05);
		ahb(1'b1, 12'h00C, 32'hFF);
		rdc("slew", 12'h00C, 32'h3F);
		settle;
		chk("oe", 32'h1F, {26'h0, q_oe});
		chk("out", 32'h05, {28'h0, q_out[3:0]});
		chk("pu", 32'h20, {26'h0, q_pu});
		chk("sl", 32'h1F, {26'h0, q_sl});
		ahb(1'b0, 12'h014, 32'h0);
		chk("pins", 32'h25, r & 32'h2F);
		rdc("data", 12'h000, 32'h25);
		ahb(1'b1, 12'h00C, 32'h0);
		settle;
		chk("sl", 32'h0, {26'h0, q_sl});
		@(posedge clk_i);
		p_oe <= 6'h01;
		ahb(1'b1, 12'h010, 32'h01);
		settle;
		chk("dbg", 32'h0, {31'h0, dbg});
		chk("pen", 32'h01, {26'h0, p_en});
		chk("oe", 32'h1F, {26'h0, q_oe});
		chk("out", 32'h04, {28'h0, q_out[3:0]});
		@(posedge clk_i);
		an <= 6'h22;
		settle;
		chk("oe", 32'h1D, {26'h0, q_oe});
		chk("pu", 32'h0, {26'h0, q_pu});
		rdc("owner", 12'h018, 32'h23);
		finish_test;
	end
endmodule
